// *** shared/strap_defines.vh ***
// Strap positions, reset defaults and reset-release timing constants
`ifndef STRAP_DEFINES_VH
`define STRAP_DEFINES_VH
`define STRAP_BOOT_WIDTH 0
`define STRAP_ARB 1
`define STRAP_FCODE 2
`define STRAP_ADDR_LO 3
`define STRAP_ADDR_HI 7
`define STRAP_BUS_PORT 8
`define STRAP_IRQ_PORT 9
`define STRAP_RESERVED 11
`define DATA_W 16
`define ADDR_CS_W 5
`define FIRST_CYCLE_DELAY 10
`define DELAY_CNT_W 4
`define RESET_VECTOR_ADDR 24'h000000
`define PROGRAM_SPACE_SUPERVISOR 3'h6
`endif

// *** design/level_sync.v ***
// Two-stage synchroniser for a single level input
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter RESET_VAL = 1'b1
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Level in and out
  input wire din,
  output reg dout
);
  reg meta_ff;

  // First stage read only by the second
  always @(posedge clock) begin
    if (rst) begin
      meta_ff <= RESET_VAL;
      dout <= RESET_VAL;
    end else begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end
endmodule // level_sync
`default_nettype wire

// *** design/reset_strap_mode_select.v ***
// Reset-time strap capture and configuration outputs
//
// Contract
// - Data lines read high unless driven low
// - Data0 low selects 8-bit boot width
// - Data1/data2 low select arbitration, function codes
// - Data3..7 low turn chip-selects into address
// - Data8 low gives bus pins to port
// - Data9 low gives interrupt pins to port
// - First bus cycle ten clocks after release
// - Boot chip-select active at reset release
// - Vectors fetched at zero, supervisor program
// - Clock strap high selects synthesizer
// - Breakpoint low at release enables debug
// - Breakpoint high at release disables debug
// - Debug enable held until next reset release
// - Breakpoint synchronised; sampled with reset pin
// - Reset synchronised, acts only with clock
`timescale 1ns/1ps
`default_nettype none
`include "strap_defines.vh"
module reset_strap_mode_select #(
  parameter FIRST_CYCLE_DELAY = `FIRST_CYCLE_DELAY
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  input wire reset_in_n,
  // Strap inputs
  input wire [`DATA_W-1:0] data_in,
  input wire [`DATA_W-1:0] data_drive_low,
  input wire clock_mode_strap,
  input wire breakpoint_request_n,
  // Data bus pull-up
  output reg [`DATA_W-1:0] data_pullup_en_ff,
  // Configuration
  output reg boot_width_16_ff,
  output reg arb_pins_ff,
  output reg function_code_out_ff,
  output reg [`ADDR_CS_W-1:0] addr_pins_ff,
  output reg bus_control_gp_port_ff,
  output reg interrupt_pin_gp_port_ff,
  output reg reserved_mode_ff,
  output reg synthesizer_oscillator_en_ff,
  output reg background_debug_mode_en_ff,
  // Reset sequencing
  output reg in_reset_ff,
  output reg boot_chip_select_en_ff,
  output reg first_bus_cycle_ff,
  output reg [23:0] reset_vector_addr_ff,
  output reg [2:0] reset_fetch_space_ff
);
  // Counter load: marker fires once the count has run down to one
  localparam integer DELAY_LOAD = FIRST_CYCLE_DELAY - 1;

  // Synchronised views of the reset and breakpoint inputs
  wire reset_sync_n;
  wire breakpoint_request_sync_n;
  wire [`DATA_W-1:0] data_pin;
  wire release_edge;
  wire [31:0] delay_load_word;
  // Release sequencing state
  reg reset_prev_ff;
  reg [`DELAY_CNT_W-1:0] delay_ff;
  reg [`DELAY_CNT_W-1:0] nxt_delay;
  reg nxt_first_bus_cycle;
  reg nxt_boot_chip_select_en;
  // Next configuration, computed from the straps
  reg nxt_boot_width_16;
  reg nxt_arb_pins;
  reg nxt_function_code_out;
  reg [`ADDR_CS_W-1:0] nxt_addr_pins;
  reg nxt_bus_control_gp_port;
  reg nxt_interrupt_pin_gp_port;
  reg nxt_reserved_mode;
  reg nxt_synthesizer_oscillator_en;
  reg nxt_background_debug_mode_en;

  // One step down, stopping at zero
  function [`DELAY_CNT_W-1:0] count_down;
    input [`DELAY_CNT_W-1:0] value;
    begin
      if (value == {`DELAY_CNT_W{1'b0}})
        count_down = value;
      else
        count_down = value - {{(`DELAY_CNT_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // Thermometer: a low line also converts every lower chip-select
  function [`ADDR_CS_W-1:0] addr_decode;
    input [`ADDR_CS_W-1:0] straps;
    integer j;
    reg low_seen;
    begin
      low_seen = 1'b0;
      addr_decode = {`ADDR_CS_W{1'b0}};
      for (j = `ADDR_CS_W - 1; j >= 0; j = j - 1) begin
        low_seen = low_seen | ~straps[j];
        addr_decode[j] = low_seen;
      end
    end
  endfunction

  // Weak pull-up: undriven lines read high
  assign data_pin = data_in & ~data_drive_low;
  assign delay_load_word = DELAY_LOAD;

  // Reset pin only takes effect on clock edges
  level_sync #(.RESET_VAL(1'b0)) u_reset_sync (
    .clock(clock),
    .rst(rst),
    .din(reset_in_n),
    .dout(reset_sync_n)
  );

  // Breakpoint takes the same two stages as the reset pin, so it is sampled at the same edge
  level_sync #(.RESET_VAL(1'b1)) u_breakpoint_request_sync (
    .clock(clock),
    .rst(rst),
    .din(breakpoint_request_n),
    .dout(breakpoint_request_sync_n)
  );

  // Held low by reset, so a pin already high after rst counts as a release
  assign release_edge = reset_sync_n & ~reset_prev_ff;

  // Counter and boot select; a new pin assertion aborts the count
  always @* begin
    nxt_delay = count_down(delay_ff);
    nxt_first_bus_cycle = 1'b0;
    nxt_boot_chip_select_en = boot_chip_select_en_ff;
    if (!reset_sync_n) begin
      nxt_delay = {`DELAY_CNT_W{1'b0}};
      nxt_boot_chip_select_en = 1'b0;
    end else if (release_edge) begin
      nxt_delay = delay_load_word[`DELAY_CNT_W-1:0];
      nxt_boot_chip_select_en = 1'b1;
    end else if (delay_ff == {{(`DELAY_CNT_W-1){1'b0}}, 1'b1}) begin
      // One-cycle marker ten clocks after release
      nxt_first_bus_cycle = 1'b1;
    end
  end

  // Straps count only on the release edge, held otherwise
  always @* begin
    nxt_boot_width_16 = boot_width_16_ff;
    nxt_arb_pins = arb_pins_ff;
    nxt_function_code_out = function_code_out_ff;
    nxt_addr_pins = addr_pins_ff;
    nxt_bus_control_gp_port = bus_control_gp_port_ff;
    nxt_interrupt_pin_gp_port = interrupt_pin_gp_port_ff;
    nxt_reserved_mode = reserved_mode_ff;
    nxt_synthesizer_oscillator_en = synthesizer_oscillator_en_ff;
    nxt_background_debug_mode_en = background_debug_mode_en_ff;
    if (release_edge) begin
      nxt_boot_width_16 = data_pin[`STRAP_BOOT_WIDTH];
      nxt_arb_pins = ~data_pin[`STRAP_ARB];
      nxt_function_code_out = ~data_pin[`STRAP_FCODE];
      nxt_addr_pins = addr_decode(data_pin[`STRAP_ADDR_HI:`STRAP_ADDR_LO]);
      nxt_bus_control_gp_port = ~data_pin[`STRAP_BUS_PORT];
      nxt_interrupt_pin_gp_port = ~data_pin[`STRAP_IRQ_PORT];
      // Flagged only; outside must keep this high
      nxt_reserved_mode = ~data_pin[`STRAP_RESERVED];
      nxt_synthesizer_oscillator_en = clock_mode_strap;
      // Relatched each release, held till next
      nxt_background_debug_mode_en = ~breakpoint_request_sync_n;
    end
  end

  // Release detector and reset status
  always @(posedge clock) begin
    if (rst) begin
      reset_prev_ff <= 1'b0;
      in_reset_ff <= 1'b1;
    end else begin
      reset_prev_ff <= reset_sync_n;
      in_reset_ff <= ~reset_sync_n;
    end
  end

  // Release sequencing registers
  always @(posedge clock) begin
    if (rst) begin
      delay_ff <= {`DELAY_CNT_W{1'b0}};
      first_bus_cycle_ff <= 1'b0;
      boot_chip_select_en_ff <= 1'b0;
    end else begin
      delay_ff <= nxt_delay;
      first_bus_cycle_ff <= nxt_first_bus_cycle;
      boot_chip_select_en_ff <= nxt_boot_chip_select_en;
    end
  end

  // Configuration registers; rst restores the all-released defaults
  always @(posedge clock) begin
    if (rst) begin
      boot_width_16_ff <= 1'b1;
      arb_pins_ff <= 1'b0;
      function_code_out_ff <= 1'b0;
      addr_pins_ff <= {`ADDR_CS_W{1'b0}};
      bus_control_gp_port_ff <= 1'b0;
      interrupt_pin_gp_port_ff <= 1'b0;
      reserved_mode_ff <= 1'b0;
      synthesizer_oscillator_en_ff <= 1'b1;
      background_debug_mode_en_ff <= 1'b0;
    end else begin
      boot_width_16_ff <= nxt_boot_width_16;
      arb_pins_ff <= nxt_arb_pins;
      function_code_out_ff <= nxt_function_code_out;
      addr_pins_ff <= nxt_addr_pins;
      bus_control_gp_port_ff <= nxt_bus_control_gp_port;
      interrupt_pin_gp_port_ff <= nxt_interrupt_pin_gp_port;
      reserved_mode_ff <= nxt_reserved_mode;
      synthesizer_oscillator_en_ff <= nxt_synthesizer_oscillator_en;
      background_debug_mode_en_ff <= nxt_background_debug_mode_en;
    end
  end

  // Fixed outputs: pull-ups kept on, outside drivers must win over them
  always @(posedge clock) begin
    if (rst) begin
      data_pullup_en_ff <= {`DATA_W{1'b1}};
      reset_vector_addr_ff <= `RESET_VECTOR_ADDR;
      reset_fetch_space_ff <= `PROGRAM_SPACE_SUPERVISOR;
    end else begin
      data_pullup_en_ff <= {`DATA_W{1'b1}};
      reset_vector_addr_ff <= `RESET_VECTOR_ADDR;
      reset_fetch_space_ff <= `PROGRAM_SPACE_SUPERVISOR;
    end
  end
endmodule // reset_strap_mode_select
`default_nettype wire

// *** verif/reset_strap_mode_select_chk.sv ***
// Port-level assertions for the strap capture block
`timescale 1ns/1ps
`default_nettype none
module strap_chk #(parameter int FIRST_CYCLE_DELAY = 10) (
  // Clock, reset and straps
  input wire logic clock, rst, clock_mode_strap, breakpoint_request_n,
  input wire logic [15:0] data_in, data_drive_low, data_pullup_en_ff,
  // Configuration
  input wire logic boot_width_16_ff, arb_pins_ff, function_code_out_ff, reserved_mode_ff,
  input wire logic bus_control_gp_port_ff, interrupt_pin_gp_port_ff,
  input wire logic [4:0] addr_pins_ff,
  input wire logic synthesizer_oscillator_en_ff, background_debug_mode_en_ff,
  // Sequencing
  input wire logic in_reset_ff, boot_chip_select_en_ff, first_bus_cycle_ff,
  input wire logic [23:0] reset_vector_addr_ff,
  input wire logic [2:0] reset_fetch_space_ff
);
  localparam int LO = FIRST_CYCLE_DELAY - 1;
  wire [15:0] pin = data_in & ~data_drive_low;
  wire [7:0] cfg = {boot_width_16_ff, arb_pins_ff, function_code_out_ff, bus_control_gp_port_ff,
    interrupt_pin_gp_port_ff, reserved_mode_ff, synthesizer_oscillator_en_ff,
    background_debug_mode_en_ff};
  wire rel = boot_chip_select_en_ff;
  // Chip-select i turns to address when strap 3+i or any higher one is low
  wire [4:0] therm = {~pin[7], ~&pin[7:6], ~&pin[7:5], ~&pin[7:4], ~&pin[7:3]};
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_pullups_on: assert property (data_pullup_en_ff == 16'hffff)
    else $error("pull-up off");
  a_strap_latch: assert property ($rose(rel) |-> cfg[7:2] ==
    $past({pin[0], ~pin[1], ~pin[2], ~pin[8], ~pin[9], ~pin[11]})) else $error("strap latch");
  a_clock_debug: assert property ($rose(rel) |-> cfg[1] == $past(clock_mode_strap)
    && cfg[0] != $past(breakpoint_request_n, 3)) else $error("clock or debug");
  a_config_hold: assert property (!$rose(rel) |-> $stable({cfg, addr_pins_ff}))
    else $error("config moved");
  a_addr_therm: assert property ($rose(rel) |-> addr_pins_ff == $past(therm))
    else $error("address straps");
  a_first_gap: assert property ($rose(rel) |-> ##[LO:FIRST_CYCLE_DELAY] first_bus_cycle_ff)
    else $error("first cycle late");
  a_pulse_once: assert property (first_bus_cycle_ff |=> !first_bus_cycle_ff)
    else $error("long pulse");
  a_boot_release: assert property ($fell(in_reset_ff) |-> rel)
    else $error("boot select off");
  a_vector_zero: assert property (reset_vector_addr_ff == 24'h000000
    && reset_fetch_space_ff == 3'h6) else $error("vector");
endmodule // strap_chk
bind reset_strap_mode_select strap_chk #(.FIRST_CYCLE_DELAY(FIRST_CYCLE_DELAY)) chk (.*);
`default_nettype wire

// *** verif/strap_driver.sv ***
// Reset-time strap driver on the far side
`timescale 1ns/1ps
`default_nettype none
module strap_driver (
  input wire logic clock, go, mc, bk,
  input wire logic [15:0] low,
  output logic reset_in_n = 1'b1,
  output logic [15:0] data_drive_low = 16'h0000,
  output logic clock_mode_strap = 1'b1,
  output logic breakpoint_request_n = 1'b1,
  output wire logic [15:0] data_in
);
  int t = 0;
  wire drv = t >= 1 && t < 12;
  // Lines let go float high on the pull-up
  assign data_in = ~data_drive_low;
  always @(posedge clock) begin
    t <= go ? 1 : (t != 0 && t < 14 ? t + 1 : 0);
    reset_in_n <= !(t >= 1 && t < 7);
    // Let go well before the first bus cycle, so no strobe meets a driven strap
    data_drive_low <= drv ? low : 16'h0000;
    breakpoint_request_n <= drv ? bk : 1'b1;
    // No pull-up here, so a released strap shows the inverse
    clock_mode_strap <= drv ? mc : ~mc;
  end
endmodule // strap_driver
`default_nettype wire

// *** verif/reset_strap_mode_select_bench.sv ***
// Strap capture bench: table of strap cases, then a mid-run reset
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %0t got %h", $time, g); end end
module reset_strap_mode_select_bench;
  logic clock = 0, rst = 1, go = 0, mc = 1, bk = 1;
  logic [15:0] low = 16'h0000;
  wire reset_in_n, clock_mode_strap, breakpoint_request_n, boot_width_16_ff, arb_pins_ff;
  wire function_code_out_ff, bus_control_gp_port_ff, interrupt_pin_gp_port_ff, reserved_mode_ff;
  wire synthesizer_oscillator_en_ff, background_debug_mode_en_ff, in_reset_ff;
  wire boot_chip_select_en_ff, first_bus_cycle_ff;
  wire [15:0] data_in, data_drive_low, data_pullup_en_ff;
  wire [4:0] addr_pins_ff;
  wire [23:0] reset_vector_addr_ff;
  wire [2:0] reset_fetch_space_ff;
  wire [12:0] cfg = {boot_width_16_ff, arb_pins_ff, function_code_out_ff, addr_pins_ff,
    bus_control_gp_port_ff, interrupt_pin_gp_port_ff, reserved_mode_ff,
    synthesizer_oscillator_en_ff, background_debug_mode_en_ff};
  int n_mismatch = 0, compares = 0;
  // Strap lines low, clock strap, breakpoint, expected configuration
  logic [30:0] rows [8] = '{{16'h0000, 2'b11, 13'b100_00000_00010},
    {16'h0001, 2'b00, 13'b000_00000_00001}, {16'h0006, 2'b11, 13'b111_00000_00010},
    {16'h0008, 2'b11, 13'b100_00001_00010}, {16'h0020, 2'b01, 13'b100_00111_00000},
    {16'h0080, 2'b10, 13'b100_11111_00011}, {16'h0300, 2'b11, 13'b100_00000_11010},
    {16'h0800, 2'b11, 13'b100_00000_00110}};
  reset_strap_mode_select dut (.*);
  strap_driver far_end (.*);
  always #10 clock = ~clock;
  task close_out;
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    int i;
    repeat (8) @(posedge clock);
    rst <= 0;
    // Pin already high after rst: one release with every strap let go
    repeat (13) @(posedge clock);
    @(negedge clock);
    `CHECK({cfg, in_reset_ff, boot_chip_select_en_ff}, 15'b100_00000_00000_01)
    @(posedge clock);
    for (int r = 0; r < 8; r++) begin
      {low, mc, bk} <= rows[r][30:13];
      go <= 1;
      @(posedge clock) go <= 0;
      repeat (6) @(negedge clock);
      `CHECK(boot_chip_select_en_ff, 1'b0)
      for (i = 0; i < 40 && first_bus_cycle_ff !== 1'b1; i++) @(negedge clock);
      `CHECK(first_bus_cycle_ff, 1'b1)
      if (i == 40) close_out;
      @(negedge clock);
      `CHECK(first_bus_cycle_ff, 1'b0)
      `CHECK(cfg, rows[r][12:0])
      repeat (4) @(posedge clock);
    end
    // Two edges of reset so the reset-defaults check sees settled defaults
    rst <= 1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    `CHECK({cfg, in_reset_ff, boot_chip_select_en_ff}, 15'b100_00000_00010_10)
    `CHECK(data_pullup_en_ff, 16'hffff)
    @(posedge clock) rst <= 0;
    // Second rst released: straps let go, a fresh release follows
    repeat (13) @(posedge clock);
    @(negedge clock);
    `CHECK({cfg, in_reset_ff, boot_chip_select_en_ff}, 15'b100_00000_00000_01)
    close_out;
  end
endmodule // reset_strap_mode_select_bench
`default_nettype wire
